/* hw/sgss_pkg.sv */
package sgss_pkg;

   // ****************************************************
   // Widths
   // ****************************************************
   localparam int DW = 16;                 // Register and gain width
   localparam int AW = 6;                  // Register address width
   localparam int COND_W = 4;              // Switch condition width
   localparam int DELAY_W = 14;            // Delay field width, 0.1 ms units
   localparam int NLOOP = 3;               // Position, velocity, thrust
   localparam int NPARAM = 5;              // Gains held per set
   localparam int NGAIN = 2 * NPARAM;      // Gains of both sets

   // ****************************************************
   // Timing
   // ****************************************************
   localparam int CLK_PERIOD_NS = 10;      // 100 MHz system clock
   localparam int TICK_TIME_NS = 100000;   // Delay and ramp unit, 0.1 ms
   localparam int TICK_CYCLES_DFLT = TICK_TIME_NS / CLK_PERIOD_NS;

   // ****************************************************
   // Register offsets (word addresses)
   // ****************************************************
   localparam logic [AW-1:0] REG_CTRL = 6'h00;       // Enable bit
   localparam logic [AW-1:0] REG_COND_BASE = 6'h01;  // Conditions, one per loop
   localparam logic [AW-1:0] REG_DELAY_BASE = 6'h04; // Delays, one per loop
   localparam logic [AW-1:0] REG_LEVEL_BASE = 6'h07; // Levels, one per loop
   localparam logic [AW-1:0] REG_HYST_BASE = 6'h0a;  // Hysteresis, one per loop
   localparam logic [AW-1:0] REG_RAMP = 6'h0d;       // Position gain ramp time
   localparam logic [AW-1:0] REG_GAIN_BASE = 6'h10;  // Gain pairs, param*2+set
   localparam logic [AW-1:0] REG_STATUS = 6'h20;     // Active set and mode
   localparam logic [AW-1:0] REG_POS_NOW = 6'h21;    // Ramping position gain

   // ****************************************************
   // Field positions and reset values
   // ****************************************************
   localparam int CTRL_EN_BIT = 0;         // second_gain_enable
   localparam int ST_SET2_BIT = 0;         // Second set active
   localparam int ST_MODE_LSB = 1;         // Control mode, two bits
   localparam int ST_PEND_BIT = 3;         // Return condition holding
   localparam logic EN_RST = 1'b0;
   localparam logic [COND_W-1:0] COND_RST = 4'h0;
   localparam logic [DELAY_W-1:0] DELAY_RST = 14'h0000;
   localparam logic [DW-1:0] LEVEL_RST = 16'h0000;
   localparam logic [DW-1:0] HYST_RST = 16'h0000;
   localparam logic [DW-1:0] RAMP_RST = 16'h0000;
   localparam logic [DW-1:0] GAIN_RST = 16'h0000;

   // ****************************************************
   // Control modes and switch conditions
   // ****************************************************
   localparam logic [1:0] MODE_POS = 2'h0;
   localparam logic [1:0] MODE_VEL = 2'h1;
   localparam logic [1:0] MODE_THR = 2'h2;
   localparam logic [COND_W-1:0] COND_FIX1 = 4'h0;
   localparam logic [COND_W-1:0] COND_FIX2 = 4'h1;
   localparam logic [COND_W-1:0] COND_NET = 4'h2;
   localparam logic [COND_W-1:0] COND_THR = 4'h3;
   localparam logic [COND_W-1:0] COND_VVAR = 4'h4;
   localparam logic [COND_W-1:0] COND_VCMD = 4'h5;
   localparam logic [COND_W-1:0] COND_PDEV = 4'h6;
   localparam logic [COND_W-1:0] COND_CMD = 4'h7;
   localparam logic [COND_W-1:0] COND_INPOS = 4'h8;
   localparam logic [COND_W-1:0] COND_SPD = 4'h9;
   localparam logic [COND_W-1:0] COND_CMD_SPD = 4'ha;

endpackage : sgss_pkg

/* hw/sgss_ramp.sv */
module sgss_ramp (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic tick,
   input wire logic [sgss_pkg::DW-1:0] target,
   input wire logic [sgss_pkg::DW-1:0] step_ticks,
   output logic [sgss_pkg::DW-1:0] gain_out
);
   import sgss_pkg::*;

   // ****************************************************
   // State
   // ****************************************************
   logic [DW-1:0] gain_ff;   // Gain now applied
   logic [DW-1:0] cnt_ff;    // Ticks since last step

   // ****************************************************
   // Ramp: one unit per step_ticks ticks
   // ****************************************************
   // Walk toward the target slowly to avoid a sudden high gain
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         gain_ff <= GAIN_RST;
         cnt_ff <= '0;
      end else if (ce) begin
         if (step_ticks == '0) begin
            // No ramp time: jump at once
            gain_ff <= target;
            cnt_ff <= '0;
         end else if (gain_ff == target) begin
            // Settled
            cnt_ff <= '0;
         end else if (tick) begin
            if (cnt_ff + 16'h0001 >= step_ticks) begin
               // Step one unit toward the target
               gain_ff <= (gain_ff < target) ? gain_ff + 16'h0001
                                             : gain_ff - 16'h0001;
               cnt_ff <= '0;
            end else begin
               cnt_ff <= cnt_ff + 16'h0001;
            end
         end
      end
   end

   assign gain_out = gain_ff;

endmodule : sgss_ramp

/* hw/sgss_switcher.sv */
module sgss_switcher #(
   parameter int TICK_CYCLES = sgss_pkg::TICK_CYCLES_DFLT
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [sgss_pkg::AW-1:0] reg_addr,
   input wire logic [sgss_pkg::DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [sgss_pkg::DW-1:0] reg_rdata,
   input wire logic [1:0] ctrl_mode,
   input wire logic [sgss_pkg::DW-1:0] pos_cmd,
   input wire logic in_position,
   input wire logic [sgss_pkg::DW-1:0] actual_speed,
   input wire logic [sgss_pkg::DW-1:0] velocity_cmd,
   input wire logic [sgss_pkg::DW-1:0] thrust_cmd,
   input wire logic [sgss_pkg::DW-1:0] pos_deviation,
   input wire logic network_gain_select_bit,
   output logic [sgss_pkg::DW-1:0] pos_gain_out,
   output logic [sgss_pkg::DW-1:0] vel_gain_out,
   output logic [sgss_pkg::DW-1:0] vel_integ_out,
   output logic [sgss_pkg::DW-1:0] vel_filt_out,
   output logic [sgss_pkg::DW-1:0] thr_filt_out,
   output logic gain_set2_out
);
   import sgss_pkg::*;

   // ****************************************************
   // Types and functions
   // ****************************************************
   typedef enum logic {SET_FIRST, SET_SECOND} sgss_set_t;
   // Address match for element idx of a register group
   function automatic logic is_reg(input logic [AW-1:0] addr,
                                   input logic [AW-1:0] base,
                                   input int idx);
      return addr == AW'(int'(base) + idx);
   endfunction : is_reg

   // Magnitude of a sign-extended value
   function automatic logic [DW:0] mag(input logic [DW:0] v);
      return v[DW] ? (~v + 17'h00001) : v;
   endfunction : mag

   // Sign extension to one extra bit
   function automatic logic [DW:0] sext(input logic [DW-1:0] v);
      return {v[DW-1], v};
   endfunction : sext

   // ****************************************************
   // Registers written by software
   // ****************************************************
   logic enable_ff;                       // second_gain_enable
   logic [COND_W-1:0] cond_ff [NLOOP];    // Condition per loop
   logic [DELAY_W-1:0] delay_ff [NLOOP];  // Return delay per loop
   logic [DW-1:0] level_ff [NLOOP];       // Level per loop
   logic [DW-1:0] hyst_ff [NLOOP];        // Hysteresis per loop
   logic [DW-1:0] ramp_ff;                // position_gain_ramp_time
   logic [DW-1:0] gain_ff [NGAIN];        // Both gain sets

   // ****************************************************
   // Block state
   // ****************************************************
   sgss_set_t set_ff;                     // Active gain set
   sgss_set_t nxt_set;                    // Its next value
   logic [DELAY_W-1:0] dly_cnt_ff;        // Ticks return held
   logic [31:0] tick_cnt_ff;              // Prescaler to 0.1 ms
   logic tick_ff;                         // One-cycle tick
   logic [DW-1:0] vel_prev_ff;            // Last velocity command
   logic set2_ff;                         // Registered set flag
   logic [DW-1:0] imm_ff [1:NPARAM-1];    // Immediate gains
   logic [DW-1:0] rdata_ff;               // Read data
   logic [DW-1:0] nxt_rdata;              // Its next value
   logic [DW-1:0] pos_now;                // Ramp output
   logic [1:0] li;                        // Active loop index
   logic mode_ok;                         // Mode has a loop
   logic [COND_W-1:0] cond;               // Active condition
   logic [DW-1:0] eff_hyst;               // Clipped hysteresis
   logic [DW:0] up_thr;                   // Level plus hysteresis
   logic [DW:0] dn_thr;                   // Level minus hysteresis
   logic [DW:0] cmd_mag;                  // Position command size
   logic [DW:0] spd_mag;                  // Actual speed size
   logic [DW:0] vcmd_mag;                 // Velocity command size
   logic [DW:0] vvar_mag;                 // Velocity command change
   logic [DW:0] thr_mag;                  // Thrust command size
   logic [DW:0] pdev_mag;                 // Position deviation size
   logic force_first;                     // Set one demanded now
   logic force_second;                    // Set two demanded now
   logic enter;                           // Shift-up condition
   logic leave;                           // Return condition
   logic delay_done;                      // Return held long enough
   logic is_pos;
   logic is_vel;

   // ****************************************************
   // Register writes
   // ****************************************************
   // Software writes land in one cycle; unmapped writes are dropped
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         enable_ff <= EN_RST;
         ramp_ff <= RAMP_RST;
         for (int i = 0; i < NLOOP; i++) begin
            cond_ff[i] <= COND_RST;
            delay_ff[i] <= DELAY_RST;
            level_ff[i] <= LEVEL_RST;
            hyst_ff[i] <= HYST_RST;
         end
         for (int g = 0; g < NGAIN; g++) gain_ff[g] <= GAIN_RST;
      end else if (ce && reg_wr) begin
         if (reg_addr == REG_CTRL) enable_ff <= reg_wdata[CTRL_EN_BIT];
         if (reg_addr == REG_RAMP) ramp_ff <= reg_wdata;
         // Per-loop settings, each loop its own copy
         for (int i = 0; i < NLOOP; i++) begin
            if (is_reg(reg_addr, REG_COND_BASE, i)) cond_ff[i] <= reg_wdata[COND_W-1:0];
            if (is_reg(reg_addr, REG_DELAY_BASE, i)) delay_ff[i] <= reg_wdata[DELAY_W-1:0];
            if (is_reg(reg_addr, REG_LEVEL_BASE, i)) level_ff[i] <= reg_wdata;
            if (is_reg(reg_addr, REG_HYST_BASE, i)) hyst_ff[i] <= reg_wdata;
         end
         // Gain table
         for (int g = 0; g < NGAIN; g++) begin
            if (is_reg(reg_addr, REG_GAIN_BASE, g)) gain_ff[g] <= reg_wdata;
         end
      end
   end

   // ****************************************************
   // Register reads
   // ****************************************************
   // Read data decode; unmapped addresses read zero
   always_comb begin
      nxt_rdata = '0;
      if (reg_addr == REG_CTRL) nxt_rdata[CTRL_EN_BIT] = enable_ff;
      if (reg_addr == REG_RAMP) nxt_rdata = ramp_ff;
      if (reg_addr == REG_STATUS) begin
         // Live state of the switcher
         nxt_rdata[ST_SET2_BIT] = set2_ff;
         nxt_rdata[ST_MODE_LSB +: 2] = ctrl_mode;
         nxt_rdata[ST_PEND_BIT] = leave;
      end
      if (reg_addr == REG_POS_NOW) nxt_rdata = pos_now;
      for (int i = 0; i < NLOOP; i++) begin
         if (is_reg(reg_addr, REG_COND_BASE, i)) nxt_rdata[COND_W-1:0] = cond_ff[i];
         if (is_reg(reg_addr, REG_DELAY_BASE, i)) nxt_rdata[DELAY_W-1:0] = delay_ff[i];
         if (is_reg(reg_addr, REG_LEVEL_BASE, i)) nxt_rdata = level_ff[i];
         if (is_reg(reg_addr, REG_HYST_BASE, i)) nxt_rdata = hyst_ff[i];
      end
      for (int g = 0; g < NGAIN; g++) begin
         if (is_reg(reg_addr, REG_GAIN_BASE, g)) nxt_rdata = gain_ff[g];
      end
   end

   // Read data stand in the cycle after the strobe only
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         rdata_ff <= '0;
      end else if (ce) begin
         rdata_ff <= reg_rd ? nxt_rdata : '0;
      end
   end

   // ****************************************************
   // Time base
   // ****************************************************
   // Prescaler giving one tick per 0.1 ms
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         tick_cnt_ff <= '0;
         tick_ff <= 1'b0;
      end else if (ce) begin
         if (tick_cnt_ff >= 32'(TICK_CYCLES - 1)) begin
            tick_cnt_ff <= '0;
            tick_ff <= 1'b1;
         end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h00000001;
            tick_ff <= 1'b0;
         end
      end
   end

   // Last velocity command for the change measure
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         vel_prev_ff <= '0;
      end else if (ce) begin
         vel_prev_ff <= velocity_cmd;
      end
   end

   // ****************************************************
   // Measures and thresholds
   // ****************************************************
   // Loop chosen by the active control mode
   always_comb begin
      li = 2'h0;
      mode_ok = 1'b1;
      unique case (ctrl_mode)
         MODE_POS: li = 2'h0;
         MODE_VEL: li = 2'h1;
         MODE_THR: li = 2'h2;
         default: mode_ok = 1'b0;  // Unused mode keeps set one
      endcase
   end

   assign cond = cond_ff[li];
   assign is_pos = (ctrl_mode == MODE_POS);
   assign is_vel = (ctrl_mode == MODE_VEL);
   // Hysteresis may not exceed the level
   assign eff_hyst = (hyst_ff[li] > level_ff[li]) ? level_ff[li] : hyst_ff[li];
   assign up_thr = {1'b0, level_ff[li]} + {1'b0, eff_hyst};
   assign dn_thr = {1'b0, level_ff[li] - eff_hyst};
   assign cmd_mag = mag(sext(pos_cmd));
   assign spd_mag = mag(sext(actual_speed));
   assign vcmd_mag = mag(sext(velocity_cmd));
   assign vvar_mag = mag(sext(velocity_cmd) - sext(vel_prev_ff));
   assign thr_mag = mag(sext(thrust_cmd));
   assign pdev_mag = mag(sext(pos_deviation));

   // ****************************************************
   // Switch conditions
   // ****************************************************
   // Decide what the active condition asks for
   always_comb begin
      force_first = 1'b0;
      force_second = 1'b0;
      enter = 1'b0;
      leave = 1'b0;
      if (!enable_ff || !mode_ok) begin
         // Switching off: set one stays
         force_first = 1'b1;
      end else begin
         case (cond)
            COND_FIX1: force_first = 1'b1;
            COND_FIX2: force_second = 1'b1;
            COND_NET: begin
               // Network bit picks the set directly
               force_second = network_gain_select_bit;
               force_first = !network_gain_select_bit;
            end
            COND_THR: begin
               enter = thr_mag > up_thr;
               leave = thr_mag < dn_thr;
            end
            COND_VVAR: begin
               // Velocity control only
               force_first = !is_vel;
               enter = vvar_mag > up_thr;
               leave = vvar_mag < dn_thr;
            end
            COND_VCMD: begin
               force_first = !(is_pos || is_vel);
               enter = vcmd_mag > up_thr;
               leave = vcmd_mag < dn_thr;
            end
            COND_PDEV: begin
               force_first = !is_pos;
               enter = pdev_mag > up_thr;
               leave = pdev_mag < dn_thr;
            end
            COND_CMD: begin
               force_first = !is_pos;
               enter = cmd_mag != '0;
               leave = cmd_mag == '0;
            end
            COND_INPOS: begin
               force_first = !is_pos;
               enter = !in_position;
               leave = in_position;
            end
            COND_SPD: begin
               force_first = !is_pos;
               enter = spd_mag > up_thr;
               leave = spd_mag < dn_thr;
            end
            COND_CMD_SPD: begin
               force_first = !is_pos;
               enter = cmd_mag != '0;
               leave = (cmd_mag == '0) && (spd_mag < dn_thr);
            end
            default: force_first = 1'b1;  // Undefined codes
         endcase
      end
   end

   // ****************************************************
   // Return delay
   // ****************************************************
   // Count ticks while the return condition holds unbroken
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         dly_cnt_ff <= '0;
      end else if (ce) begin
         if (set_ff != SET_SECOND || !leave || force_first || force_second) begin
            dly_cnt_ff <= '0;
         end else if (tick_ff && dly_cnt_ff != '1) begin
            dly_cnt_ff <= dly_cnt_ff + 14'h0001;
         end
      end
   end

   assign delay_done = dly_cnt_ff >= delay_ff[li];

   // ****************************************************
   // Gain set selection
   // ****************************************************
   // Shift up at once; shift down after the delay, or at once when set one is forced
   always_comb begin
      nxt_set = set_ff;
      unique case (set_ff)
         SET_FIRST: begin
            if (force_second || (!force_first && enter)) nxt_set = SET_SECOND;
         end
         SET_SECOND: begin
            if (force_first || (!force_second && leave && delay_done)) begin
               nxt_set = SET_FIRST;
            end
         end
      endcase
   end

   // Active set register
   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         set_ff <= SET_FIRST;
         set2_ff <= 1'b0;
      end else if (ce) begin
         set_ff <= nxt_set;
         set2_ff <= (nxt_set == SET_SECOND);
      end
   end

   // ****************************************************
   // Gain outputs
   // ****************************************************
   // Non-position gains follow the set without a ramp
   generate
      for (genvar gp = 1; gp < NPARAM; gp++) begin : g_imm
         always_ff @(posedge sys_clk) begin
            if (!rstn) begin
               imm_ff[gp] <= GAIN_RST;
            end else if (ce) begin
               imm_ff[gp] <= gain_ff[2 * gp + int'(nxt_set == SET_SECOND)];
            end
         end
      end
   endgenerate

   // Position gain ramps toward the selected set
   sgss_ramp u_ramp (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .ce(ce),
      .tick(tick_ff),
      .target(gain_ff[int'(set_ff == SET_SECOND)]),
      .step_ticks(ramp_ff),
      .gain_out(pos_now)
   );

   assign pos_gain_out = pos_now;
   assign vel_gain_out = imm_ff[1];
   assign vel_integ_out = imm_ff[2];
   assign vel_filt_out = imm_ff[3];
   assign thr_filt_out = imm_ff[4];
   assign gain_set2_out = set2_ff;
   assign reg_rdata = rdata_ff;

endmodule : sgss_switcher

/* bench/sgss_monitor.sv */
module sgss_monitor (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic [sgss_pkg::AW-1:0] reg_addr,
   input wire logic [sgss_pkg::DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic [1:0] ctrl_mode,
   input wire logic [sgss_pkg::DW-1:0] pos_cmd,
   input wire logic in_position,
   input wire logic network_gain_select_bit,
   input wire logic [sgss_pkg::DW-1:0] vel_gain_out,
   input wire logic gain_set2_out
);
   timeunit 1ns;
   timeprecision 1ns;
   import sgss_pkg::*;
   logic [COND_W-1:0] c_ff; // Shadow position condition
   logic en_ff; // Shadow enable
   logic pok, s2, nb, f2; // Position mode, set, select, fixed two
   assign pok = ce && en_ff && ctrl_mode == MODE_POS;
   assign s2 = gain_set2_out;
   assign nb = network_gain_select_bit;
   assign f2 = c_ff == COND_FIX2;
   // Follow host writes
   always_ff @(posedge sys_clk) begin
      if (!rstn) c_ff <= COND_RST;
      else if (ce && reg_wr && reg_addr == REG_COND_BASE) c_ff <= reg_wdata[COND_W-1:0];
   end
   always_ff @(posedge sys_clk) begin
      if (!rstn) en_ff <= EN_RST;
      else if (ce && reg_wr && reg_addr == REG_CTRL) en_ff <= reg_wdata[CTRL_EN_BIT];
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   cmd_in_a: assert property (pok && c_ff == COND_CMD && |pos_cmd |=> s2)
      else $error("no entry on command");
   inpos_in_a: assert property (pok && c_ff == COND_INPOS && !in_position |=> s2)
      else $error("no entry on positioning");
   fix_set_a: assert property (pok && c_ff <= COND_FIX2 |=> s2 == $past(f2))
      else $error("fixed set not kept");
   net_sel_a: assert property (pok && c_ff == COND_NET |=> s2 == $past(nb))
      else $error("network select not followed");
   off_fix_a: assert property (ce && !en_ff |=> !s2)
      else $error("switched while disabled");
   no_loop_a: assert property (ce && ctrl_mode == 2'h3 |=> !s2)
      else $error("set two without a loop");
   ce_hold_a: assert property (!ce |=> $stable(s2) && $stable(vel_gain_out))
      else $error("state moved with enable low");
   gain_move_a: assert property ($changed(s2) |-> $changed(vel_gain_out))
      else $error("velocity gain lagged the set");
endmodule : sgss_monitor

/* bench/sgss_partner.sv */
module sgss_partner (
   input wire logic sys_clk,
   input wire logic go, // Start a move
   input wire logic [15:0] len, // Move length, cycles
   input wire logic [15:0] spd, // Measured speed
   input wire logic net, // Host gain select
   output logic [15:0] pos_cmd = 16'h0000,
   output logic [15:0] actual_speed = 16'h0000,
   output logic in_position = 1'b1,
   output logic network_gain_select_bit = 1'b0
);
   timeunit 1ns;
   timeprecision 1ns;
   int left = 0; // Command cycles left
   // Loop model: command steps, position settles a cycle later
   always @(posedge sys_clk) begin
      left <= go ? int'(len) : (left > 0 ? left - 1 : 0);
      pos_cmd <= left > 0 ? 16'h0010 : 16'h0000;
      in_position <= left == 0 && pos_cmd == 16'h0000;
      actual_speed <= spd;
      network_gain_select_bit <= net;
   end
endmodule : sgss_partner

/* bench/sgss_switcher_bench.sv */
module sgss_switcher_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import sgss_pkg::*;
   localparam int TK = 4; // Cycles per tick
   localparam int D = 3; // Return delay, ticks
   logic sys_clk = 0, rstn = 0, ce = 1, reg_wr = 0, reg_rd = 0, go = 0, net = 0;
   logic [AW-1:0] reg_addr = '0;
   logic [DW-1:0] reg_wdata = '0, len = '0, spd = '0, reg_rdata, pos_cmd, actual_speed;
   logic [DW-1:0] pg, vg, vi, vf, tf; // Gain outputs
   logic [1:0] ctrl_mode = MODE_POS;
   logic in_position, network_gain_select_bit, gain_set2_out;
   int err_count = 0, comparisons = 0, seed = 32'h4878, n;
   int conds[$] = '{COND_CMD, COND_INPOS, COND_CMD_SPD}; // Delayed return modes
   logic [DW-1:0] spds[$] = '{16'h0078, 16'hff87, 16'h0051, 16'h004f}; // Level 100, hyst 20
   logic exps[$] = '{1'b0, 1'b1, 1'b1, 1'b0}; // Set after each speed
   initial forever #5 sys_clk = ~sys_clk;
   sgss_partner pm (.sys_clk, .go, .len, .spd, .net, .pos_cmd, .actual_speed, .in_position,
      .network_gain_select_bit);
   sgss_switcher #(.TICK_CYCLES(TK)) dut (.sys_clk, .rstn, .ce, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .ctrl_mode, .pos_cmd, .in_position, .actual_speed,
      .velocity_cmd(16'h0000), .thrust_cmd(16'h0000), .pos_deviation(16'h0000),
      .network_gain_select_bit, .pos_gain_out(pg), .vel_gain_out(vg), .vel_integ_out(vi),
      .vel_filt_out(vf), .thr_filt_out(tf), .gain_set2_out);
   function automatic logic [DW-1:0] g(int i); // Gain stored at index i
      return 16'h0010 + DW'(4 * i);
   endfunction : g
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : summarize
   task automatic chk(string nm, logic [63:0] e, logic [63:0] s);
      comparisons++;
      if (s !== e) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic wr(logic [AW-1:0] a, logic [DW-1:0] v);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(logic [AW-1:0] a, logic [DW-1:0] e);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk("read data", 64'(e), 64'(reg_rdata));
   endtask : rd
   task automatic cyc(int k); // Pass k edges, sample after the last
      repeat (k) @(posedge sys_clk);
      #1;
   endtask : cyc
   task automatic mv(logic [DW-1:0] l); // Order one move
      @(posedge sys_clk);
      go <= 1'b1;
      len <= l;
      @(posedge sys_clk);
      go <= 1'b0;
   endtask : mv
   task automatic wset(logic e, int mx); // Bounded wait for set, cycles in n
      #1 n = 0;
      while (gain_set2_out !== e) begin
         cyc(1);
         n++;
         if (n > mx) begin
            $display("unexpected set wait: expected %b seen %b", e, gain_set2_out);
            err_count++;
            summarize();
         end
      end
      comparisons++;
   endtask : wset
   initial begin
      repeat (10) @(posedge sys_clk);
      rstn <= 1'b1;
      rd(REG_STATUS, 16'h0000);
      rd(6'h3f, 16'h0000);
      for (int i = 0; i < NGAIN; i++) wr(REG_GAIN_BASE + AW'(i), g(i));
      wr(REG_CTRL, 16'h0001);
      for (int c = 0; c < 3; c++) begin
         @(posedge sys_clk) net <= 1'($random(seed));
         wr(REG_COND_BASE, DW'(c));
         cyc(3);
         chk("fixed set", 64'(c == 1 || (c == 2 && net)), 64'(gain_set2_out));
      end
      $display("test select done");
      wr(REG_COND_BASE, 16'h0000);
      wr(REG_RAMP, 16'h0001);
      wr(REG_COND_BASE, 16'h0001);
      cyc(8);
      chk("ramping", 64'(1), 64'(pg > g(0) && pg < g(1)));
      @(posedge sys_clk) ce <= 1'b0;
      wr(REG_COND_BASE, 16'h0000);
      cyc(20);
      chk("frozen set", 64'(1), 64'(gain_set2_out));
      @(posedge sys_clk) ce <= 1'b1;
      cyc(16);
      rd(REG_POS_NOW, g(1));
      wr(REG_RAMP, 16'h0000);
      wr(REG_DELAY_BASE, 16'h0003);
      wr(REG_LEVEL_BASE, 16'h0064);
      $display("test ramp done");
      foreach (conds[k]) begin
         wr(REG_COND_BASE, DW'(conds[k]));
         wset(1'b0, 20);
         mv(16'h0005);
         wset(1'b1, 4);
         chk("set two gains", {g(3), g(5), g(7), g(9)}, {vg, vi, vf, tf});
         cyc(6);
         chk("stepped gain", 64'(g(1)), 64'(pg));
         mv(16'h0001);
         wset(1'b0, D * TK + 6);
         chk("return wait", 64'(1), 64'(n >= (D - 1) * TK + 2));
         chk("set one gains", {g(2), g(4), g(6), g(8)}, {vg, vi, vf, tf});
      end
      $display("test delay done");
      wr(REG_HYST_BASE, 16'h0014);
      wr(REG_COND_BASE, 16'h0009);
      foreach (spds[k]) begin
         @(posedge sys_clk) spd <= spds[k];
         cyc(20);
         chk("speed set", 64'(exps[k]), 64'(gain_set2_out));
      end
      wr(REG_COND_BASE, 16'h000a);
      @(posedge sys_clk) spd <= 16'h0096;
      mv(16'h0002);
      cyc(30);
      chk("speed hold", 64'(1), 64'(gain_set2_out));
      @(posedge sys_clk) spd <= 16'h0000;
      wset(1'b0, 20);
      wr(REG_HYST_BASE, 16'h00c8);
      wr(REG_COND_BASE, 16'h0009);
      @(posedge sys_clk) spd <= 16'h00c9;
      wset(1'b1, 4);
      wr(REG_COND_BASE + 6'h01, 16'h0009);
      @(posedge sys_clk) ctrl_mode <= MODE_VEL;
      wset(1'b0, 4);
      wr(REG_COND_BASE + 6'h01, 16'h0001);
      wset(1'b1, 4);
      @(posedge sys_clk) ctrl_mode <= 2'h3;
      wset(1'b0, 4);
      @(posedge sys_clk) ctrl_mode <= MODE_POS;
      wset(1'b1, 4);
      wr(REG_CTRL, 16'h0000);
      wset(1'b0, 4);
      $display("test mode done");
      summarize();
   end
endmodule : sgss_switcher_bench
bind sgss_switcher sgss_monitor mon (.sys_clk, .rstn, .ce, .reg_addr, .reg_wdata, .reg_wr,
   .ctrl_mode, .pos_cmd, .in_position, .network_gain_select_bit, .vel_gain_out, .gain_set2_out);
